// ### dv/ifrw_link_asserts.sv
`timescale 1ns/1ps
module ifrw_link_asserts
  import ifrw_pkg::*;
#(
  parameter int unsigned SRST_WAIT = 50
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // link signals
  input wire logic sclk_in,
  input wire logic host_data_in,
  input wire logic host_data_oe_n_in,
  input wire logic dev_data_in,
  input wire logic dev_data_oe_n_in,
  input wire logic data_in
);
  logic sclk_q;
  logic oe_q;
  logic [4:0] fall_q;
  logic [15:0] word_q;
  logic [31:0] wait_q;

  ////////////////////////////////////////////////////////////////////////////////
  // frame tracker, counts falls since the host took the line
  always_ff @(posedge clk_in) begin
    sclk_q <= sys_rst_in | sclk_in;
    oe_q <= sys_rst_in | host_data_oe_n_in;
    if (sys_rst_in || (oe_q && !host_data_oe_n_in)) begin
      fall_q <= 5'h00;
    end else if (sclk_q && !sclk_in) begin
      fall_q <= fall_q + 5'h01;
      word_q <= {word_q[14:0], data_in};
    end
    if (sys_rst_in) begin
      wait_q <= 32'h0;
    end else if (!oe_q && host_data_oe_n_in && fall_q == 5'h10 &&
                 word_q == {2'b10, ADDR_SOFT_RESET, SOFT_RESET_VALUE}) begin
      wait_q <= SRST_WAIT;
    end else if (wait_q != 32'h0) begin
      wait_q <= wait_q - 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_NO_CONTENTION: assert property (host_data_oe_n_in || dev_data_oe_n_in)
    else $error("both ends drive the data line");
  AST_DATA_ON_RISE: assert property (!sclk_in && $stable(sclk_in) && !host_data_oe_n_in
    && $stable(host_data_oe_n_in) |-> $stable(host_data_in))
    else $error("host data moved while clock low");
  AST_DEV_ON_RISE: assert property (!sclk_in && $stable(sclk_in) && !dev_data_oe_n_in
    && $stable(dev_data_oe_n_in) |-> $stable(dev_data_in))
    else $error("device data moved while clock low");
  AST_LOW_HALF: assert property ($fell(sclk_in)
    |-> !sclk_in[*8] ##1 !sclk_in[*5] ##1 sclk_in)
    else $error("clock low phase not 13 cycles");
  AST_START_ONE: assert property ($fell(host_data_oe_n_in) |-> host_data_in && sclk_in)
    else $error("frame does not open with a one");
  AST_FRAME_LEN: assert property ($rose(host_data_oe_n_in) |-> fall_q == 5'h10
    || (fall_q == 5'h08 && word_q[6]))
    else $error("host released line at wrong bit");
  AST_DEV_WINDOW: assert property ($fell(dev_data_oe_n_in)
    |-> fall_q == 5'h08 && word_q[6])
    else $error("device drove outside a read");
  AST_DEV_RELEASE: assert property ($rose(dev_data_oe_n_in) |-> fall_q == 5'h10)
    else $error("device released at wrong bit");
  AST_DEV_PROMPT: assert property ($rose(host_data_oe_n_in) && fall_q == 5'h08
    |-> ##[1:10] !dev_data_oe_n_in)
    else $error("device late with read data");
  AST_SRST_WAIT: assert property ($fell(host_data_oe_n_in) |-> wait_q == 32'h0)
    else $error("frame too soon after soft reset");
  AST_IDLE_HIGH: assert property ($rose(host_data_oe_n_in) && fall_q == 5'h10
    |-> sclk_in[*3])
    else $error("clock not idle high after frame");
endmodule : ifrw_link_asserts

// ### dv/test_indirect_feature_register_writer.sv
`timescale 1ns/1ps
module test_indirect_feature_register_writer;
  import ifrw_pkg::*;
  // short soft reset wait keeps the run small
  localparam int unsigned WAIT_SIM = 50;
  localparam int MAX_CYC = 60000;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  ifrw_bank_type feature_bank_out;
  logic [7:0] pointer_out;
  logic commit_pulse_out;
  logic calib_pulse_out;
  logic sleep_out;
  logic frame_error_out;
  ifrw_bank_type exp_bank = '0;
  logic [7:0] exp_ptr = 8'h00;
  logic [7:0] exp_lo = 8'h00;
  logic [7:0] exp_hi = 8'h00;
  logic [15:0] cap_q = 16'h0;
  logic sclk_q = 1'b1;
  logic [31:0] rd;
  logic er;
  logic [15:0] w;
  int err_total = 0;
  int total_checks = 0;
  int commits = 0;
  int calibs = 0;
  int exp_commits = 0;
  int exp_calibs = 0;
  int cyc = 0;
  int seed = 32'h4F6D;
  int i;

  always #2.5 clk_in = ~clk_in;

  ifrw_link_if link();
  ifrw_host #(.SRST_WAIT(WAIT_SIM)) i_ifrw_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .link(link));
  ifrw_device i_ifrw_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link),
    .feature_bank_out(feature_bank_out), .pointer_out(pointer_out),
    .commit_pulse_out(commit_pulse_out), .calib_pulse_out(calib_pulse_out),
    .sleep_out(sleep_out), .frame_error_out(frame_error_out));
  ifrw_link_asserts #(.SRST_WAIT(WAIT_SIM)) i_ifrw_link_asserts (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .sclk_in(link.sclk), .host_data_in(link.host_data),
    .host_data_oe_n_in(link.host_data_oe_n), .dev_data_in(link.dev_data),
    .dev_data_oe_n_in(link.dev_data_oe_n), .data_in(link.data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // wide enough for the sleep flag beside the whole bank
  task automatic check(input logic [336:0] seen, input logic [336:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check

  // wire monitor, samples the line where the device does
  always @(posedge clk_in) begin
    sclk_q <= link.sclk;
    cyc <= cyc + 1;
    if (sclk_q && !link.sclk) begin
      cap_q <= {cap_q[14:0], link.data};
    end
    if (commit_pulse_out === 1'b1) begin
      commits <= commits + 1;
    end
    if (calib_pulse_out === 1'b1) begin
      calibs <= calibs + 1;
    end
    if (!sys_rst_in && frame_error_out !== 1'b0) begin
      check(frame_error_out, 1'b0);
    end
    if (cyc == MAX_CYC) begin
      err_total++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 3000) begin
      apb(1'b0, HOST_STAT_OFS, 32'h0);
      n++;
    end
    // a host stuck busy ends the run as a failure
    if (rd[STAT_BUSY_BIT] !== 1'b0) begin
      err_total++;
      conclude();
    end
  endtask : wait_idle

  function automatic logic [7:0] exp_rd(input logic [5:0] a);
    if (a == ADDR_FEATURE_POINTER) return exp_ptr;
    if (a == ADDR_STAGED_LOW) return exp_lo;
    if (a == ADDR_STAGED_HIGH) return exp_hi;
    return 8'h00;
  endfunction : exp_rd

  task automatic link_op(input logic rdop, input logic [5:0] a, input logic [7:0] d);
    apb(1'b1, HOST_CMD_OFS, {17'h0, rdop, a, d});
    wait_idle();
    check(cap_q, {1'b1, rdop, a, rdop ? exp_rd(a) : d});
    if (rdop) begin
      check(rd[15:8], exp_rd(a));
    end else begin
      if (a == ADDR_FEATURE_POINTER) exp_ptr = d;
      if (a == ADDR_STAGED_LOW) exp_lo = d;
      if (a == ADDR_STAGED_HIGH) exp_hi = d;
      if (a == ADDR_COMMIT_TRIGGER && d == COMMIT_VALUE && exp_ptr <= FEAT_LAST_ADDR) begin
        exp_bank[exp_ptr[4:0]] = {exp_hi, exp_lo};
        exp_commits++;
      end
      check(pointer_out, exp_ptr);
      check(feature_bank_out, exp_bank);
    end
  endtask : link_op

  task automatic soft_rst;
    apb(1'b1, HOST_SRST_OFS, 32'($random(seed)));
    wait_idle();
    exp_bank = '0;
    exp_ptr = 8'h00;
    exp_lo = 8'h00;
    exp_hi = 8'h00;
    exp_calibs++;
    check(cap_q, {2'b10, ADDR_SOFT_RESET, SOFT_RESET_VALUE});
    check(calibs, exp_calibs);
    check({sleep_out, feature_bank_out}, {1'b1, exp_bank});
  endtask : soft_rst

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check({sleep_out, feature_bank_out}, {1'b1, exp_bank});
    soft_rst();
    apb(1'b0, 8'h0C, 32'h0);
    check({rd, er}, 33'h1);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    check(er, 1'b1);
    apb(1'b0, HOST_CMD_OFS, 32'h0);
    check({rd, er}, 33'h0);
    // edge addresses first, then random ones
    for (i = 0; i < 10; i++) begin
      w = 16'($random(seed));
      link_op(1'b0, ADDR_FEATURE_POINTER, (i == 0) ? 8'h00 : (i == 1) ? FEAT_LAST_ADDR :
        8'($unsigned($random(seed)) % FEAT_CNT));
      link_op(1'b0, ADDR_STAGED_LOW, w[7:0]);
      link_op(1'b0, ADDR_STAGED_HIGH, w[15:8]);
      link_op(1'b0, ADDR_COMMIT_TRIGGER, COMMIT_VALUE);
    end
    link_op(1'b0, ADDR_FEATURE_POINTER, 8'h03);
    link_op(1'b0, ADDR_COMMIT_TRIGGER, COMMIT_VALUE);
    link_op(1'b0, ADDR_COMMIT_TRIGGER, 8'h02);
    link_op(1'b0, ADDR_FEATURE_POINTER, 8'h16);
    link_op(1'b0, ADDR_COMMIT_TRIGGER, COMMIT_VALUE);
    // a command while busy is dropped
    apb(1'b1, HOST_CMD_OFS, {17'h0, 1'b1, ADDR_FEATURE_POINTER, 8'h00});
    apb(1'b1, HOST_CMD_OFS, {17'h0, 1'b0, ADDR_FEATURE_POINTER, 8'h77});
    wait_idle();
    check(cap_q, {2'b11, ADDR_FEATURE_POINTER, exp_ptr});
    check(pointer_out, exp_ptr);
    link_op(1'b1, ADDR_FEATURE_POINTER, 8'h00);
    link_op(1'b1, ADDR_STAGED_LOW, 8'h00);
    link_op(1'b1, ADDR_STAGED_HIGH, 8'h00);
    link_op(1'b1, ADDR_COMMIT_TRIGGER, 8'h00);
    check(commits, exp_commits);
    soft_rst();
    conclude();
  end
endmodule : test_indirect_feature_register_writer

// ### hdl/ifrw_device.sv
// Implementation choice: register access over the serial link.
`timescale 1ns/1ps
module ifrw_device
  import ifrw_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // serial link
  ifrw_link_if.device link,
  // user side
  output ifrw_bank_type feature_bank_out,
  output logic [7:0] pointer_out,
  output logic commit_pulse_out,
  output logic calib_pulse_out,
  output logic sleep_out,
  output logic frame_error_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [CNT_W-1:0] cnt;
    logic [6:0] idle;
    logic sclk_prev;
    logic reading;
    logic [7:0] rd_shift;
    logic out_bit;
    logic oe_n;
    logic [7:0] ptr;
    logic [7:0] lo;
    logic [7:0] hi;
    ifrw_bank_type bank;
    logic commit;
    logic calib;
    logic sleep;
    logic frame_err;
  } ifrw_dev_st_type;

  ifrw_dev_st_type q;
  ifrw_dev_st_type d;

  logic sclk_s;
  logic data_s;
  logic rise;
  logic fall;
  logic [FRAME_BITS-1:0] nsh;
  logic [5:0] w_addr;
  logic [7:0] w_data;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  ifrw_sync2 u_sync_clk (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(link.sclk),
    .sync_out(sclk_s)
  );

  ifrw_sync2 u_sync_data (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(link.data),
    .sync_out(data_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] read_mux(
    input logic [5:0] addr,
    input logic [7:0] ptr,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [7:0] r;
    r = 8'h00;
    unique case (addr)
      ADDR_FEATURE_POINTER: r = ptr;
      ADDR_STAGED_LOW: r = lo;
      ADDR_STAGED_HIGH: r = hi;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : read_mux

  assign rise = sclk_s & ~q.sclk_prev;
  assign fall = ~sclk_s & q.sclk_prev;
  assign nsh = {q.shift[FRAME_BITS-2:0], data_s};
  assign w_addr = nsh[ADDR_MSB:ADDR_LSB];
  assign w_data = nsh[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.commit = 1'b0;
    d.calib = 1'b0;
    d.frame_err = 1'b0;
    d.sclk_prev = sclk_s;

    // clock parked high too long: drop a partial frame
    if (sclk_s) begin
      if (q.idle != 7'(LINK_IDLE_CYC)) begin
        d.idle = q.idle + 7'h01;
      end else if (q.cnt != 5'h00) begin
        d.cnt = 5'h00;
        d.reading = 1'b0;
        d.oe_n = 1'b1;
        d.frame_err = 1'b1;
      end
    end else begin
      d.idle = 7'h00;
    end

    if (rise && q.reading) begin
      d.oe_n = 1'b0;
      d.out_bit = q.rd_shift[7];
      d.rd_shift = {q.rd_shift[6:0], 1'b0};
    end

    if (fall) begin
      if (q.cnt == 5'h00 && !data_s) begin
        d.cnt = 5'h00;
      end else begin
        d.shift = nsh;
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == CNT_HEAD_LAST && nsh[HEAD_BITS-2]) begin
          d.reading = 1'b1;
          d.rd_shift = read_mux(nsh[5:0], q.ptr, q.lo, q.hi);
        end
        if (q.cnt == CNT_FRAME_LAST) begin
          d.cnt = 5'h00;
          d.reading = 1'b0;
          d.oe_n = 1'b1;
          if (!q.reading && !nsh[BIT_READ]) begin
            unique case (w_addr)
              ADDR_FEATURE_POINTER: begin
                d.ptr = w_data;
              end
              ADDR_STAGED_LOW: begin
                d.lo = w_data;
              end
              ADDR_STAGED_HIGH: begin
                d.hi = w_data;
              end
              ADDR_COMMIT_TRIGGER: begin
                if (w_data == COMMIT_VALUE && q.ptr <= FEAT_LAST_ADDR) begin
                  d.bank[q.ptr[4:0]] = {q.hi, q.lo};
                  d.commit = 1'b1;
                end
              end
              ADDR_SOFT_RESET: begin
                if (w_data == SOFT_RESET_VALUE) begin
                  for (int i = 0; i < FEAT_CNT; i++) begin
                    d.bank[i] = FEAT_RESET;
                  end
                  d.ptr = BYTE_RESET;
                  d.lo = BYTE_RESET;
                  d.hi = BYTE_RESET;
                  d.calib = 1'b1;
                  d.sleep = 1'b1;
                end
              end
              default: begin
                d.cnt = 5'h00;
              end
            endcase
          end
        end
      end
    end

    if (sys_rst_in) begin
      d = '0;
      d.sclk_prev = 1'b1;
      d.oe_n = 1'b1;
      d.out_bit = 1'b1;
      d.sleep = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and outputs

  always_ff @(posedge clk_in) begin
    q <= d;
  end

  // no wait tracking here; host paces commands
  assign link.dev_data = q.out_bit;
  assign link.dev_data_oe_n = q.oe_n;
  assign feature_bank_out = q.bank;
  assign pointer_out = q.ptr;
  assign commit_pulse_out = q.commit;
  assign calib_pulse_out = q.calib;
  assign sleep_out = q.sleep;
  assign frame_error_out = q.frame_err;

endmodule : ifrw_device

// ### hdl/ifrw_host.sv
`timescale 1ns/1ps
module ifrw_host
  import ifrw_pkg::*;
#(
  parameter int unsigned SRST_WAIT = SRST_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // serial link
  ifrw_link_if.host link
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [4:0] div;
    logic sclk;
    logic [CNT_W-1:0] bitn;
    logic [FRAME_BITS-1:0] shift;
    logic rd;
    logic srst;
    logic in_frame;
    logic waiting;
    logic [17:0] wcnt;
    logic dat;
    logic oe_n;
    logic [7:0] rd_data;
    logic [31:0] prdata;
  } ifrw_host_st_type;

  ifrw_host_st_type q;
  ifrw_host_st_type d;

  logic data_s;
  logic busy;
  logic acc;
  logic mapped;
  logic [FRAME_BITS-1:0] frame;

  ifrw_sync2 u_sync_data (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(link.data),
    .sync_out(data_s)
  );

  assign busy = q.in_frame | q.waiting;
  assign acc = psel_in & penable_in;
  assign mapped = paddr_in == HOST_CMD_OFS || paddr_in == HOST_STAT_OFS
    || paddr_in == HOST_SRST_OFS;
  // start one, read bit, address, data
  assign frame = {1'b1, pwdata_in[CMD_READ_BIT], pwdata_in[CMD_ADDR_LSB +: 6],
    pwdata_in[CMD_DATA_LSB +: 8]};

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    // read data registered in setup, shown in access
    if (psel_in && !penable_in) begin
      d.prdata = 32'h0000_0000;
      if (paddr_in == HOST_STAT_OFS) begin
        d.prdata[STAT_BUSY_BIT] = busy;
        d.prdata[STAT_RDATA_LSB +: 8] = q.rd_data;
      end
    end
    // one frame per command or soft reset write; busy writes dropped
    if (acc && pwrite_in && !busy) begin
      if (paddr_in == HOST_CMD_OFS) begin
        d.shift = frame;
        d.rd = frame[BIT_READ];
        d.srst = 1'b0;
      end else if (paddr_in == HOST_SRST_OFS) begin
        d.shift = {1'b1, 1'b0, ADDR_SOFT_RESET, SOFT_RESET_VALUE};
        d.rd = 1'b0;
        d.srst = 1'b1;
      end
      if (paddr_in == HOST_CMD_OFS || paddr_in == HOST_SRST_OFS) begin
        d.in_frame = 1'b1;
        d.sclk = 1'b1;
        d.bitn = 5'h00;
        d.div = 5'(LINK_HALF_CYC - 1);
        d.oe_n = 1'b0;
        d.dat = 1'b1;
      end
    end else if (q.in_frame) begin
      if (q.div != 5'h00) begin
        d.div = q.div - 5'h01;
      end else begin
        d.div = 5'(LINK_HALF_CYC - 1);
        if (q.sclk) begin
          d.sclk = 1'b0;
          if (q.rd && q.bitn >= 5'(HEAD_BITS)) begin
            d.rd_data = {q.rd_data[6:0], data_s};
          end
        end else if (q.bitn == CNT_FRAME_LAST) begin
          d.sclk = 1'b1;
          d.in_frame = 1'b0;
          d.oe_n = 1'b1;
          d.dat = 1'b1;
          if (q.srst) begin
            d.waiting = 1'b1;
            d.wcnt = 18'(SRST_WAIT);
          end
        end else begin
          d.sclk = 1'b1;
          d.bitn = q.bitn + 5'h01;
          d.shift = {q.shift[FRAME_BITS-2:0], 1'b0};
          d.dat = q.shift[FRAME_BITS-2];
          if (q.rd && q.bitn == CNT_HEAD_LAST) begin
            d.oe_n = 1'b1;
          end
        end
      end
    end else if (q.waiting) begin
      if (q.wcnt <= 18'h00001) begin
        d.waiting = 1'b0;
        d.wcnt = 18'h00000;
      end else begin
        d.wcnt = q.wcnt - 18'h00001;
      end
    end

    if (sys_rst_in) begin
      d = '0;
      d.sclk = 1'b1;
      d.dat = 1'b1;
      d.oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_out = q.prdata;
  assign pready_out = acc;
  assign pslverr_out = acc & ~mapped;
  assign link.sclk = q.sclk;
  assign link.host_data = q.dat;
  assign link.host_data_oe_n = q.oe_n;

endmodule : ifrw_host

// ### hdl/ifrw_link_if.sv
`timescale 1ns/1ps
interface ifrw_link_if;
  logic sclk;
  logic host_data;
  logic host_data_oe_n;
  logic dev_data;
  logic dev_data_oe_n;
  logic data;

  // pull-up when nobody drives the line
  assign data = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 1'b1);

  modport host (
    output sclk,
    output host_data,
    output host_data_oe_n,
    input data
  );

  modport device (
    input sclk,
    input data,
    output dev_data,
    output dev_data_oe_n
  );
endinterface : ifrw_link_if

// ### hdl/ifrw_pkg.sv
package ifrw_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // serial frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned HEAD_BITS = 8;
  localparam int unsigned BIT_START = 15;
  localparam int unsigned BIT_READ = 14;
  localparam int unsigned ADDR_MSB = 13;
  localparam int unsigned ADDR_LSB = 8;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] CNT_HEAD_LAST = 5'h07;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h0F;

  ////////////////////////////////////////////////////////////////////////////////
  // device register map on the serial port
  localparam logic [5:0] ADDR_FEATURE_POINTER = 6'h18;
  localparam logic [5:0] ADDR_STAGED_LOW = 6'h19;
  localparam logic [5:0] ADDR_STAGED_HIGH = 6'h1A;
  localparam logic [5:0] ADDR_COMMIT_TRIGGER = 6'h25;
  localparam logic [7:0] COMMIT_VALUE = 8'h01;
  localparam logic [5:0] ADDR_SOFT_RESET = 6'h3F;
  localparam logic [7:0] SOFT_RESET_VALUE = 8'hA5;
  localparam int unsigned FEAT_W = 16;
  localparam int unsigned FEAT_CNT = 21;
  localparam logic [7:0] FEAT_LAST_ADDR = 8'h15;
  localparam logic [15:0] FEAT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  typedef logic [FEAT_CNT-1:0][FEAT_W-1:0] ifrw_bank_type;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned LINK_HALF_NS = 65;
  localparam int unsigned LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SRST_WAIT_MS = 1;
  localparam int unsigned SRST_WAIT_CYC = SRST_WAIT_MS * CLK_MHZ * 1000;
  localparam int unsigned LINK_IDLE_CYC = 64;

  ////////////////////////////////////////////////////////////////////////////////
  // host controller registers on apb
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_SRST_OFS = 8'h08;
  localparam int unsigned CMD_DATA_LSB = 0;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_READ_BIT = 14;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_RDATA_LSB = 8;

endpackage : ifrw_pkg

// ### hdl/ifrw_sync2.sv
`timescale 1ns/1ps
module ifrw_sync2 (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // async level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ifrw_sync_st_type;

  ifrw_sync_st_type q;
  ifrw_sync_st_type d;

  always_comb begin
    d.s1 = async_in;
    d.s2 = q.s1;
    if (sys_rst_in) begin
      d = '{s1: 1'b1, s2: 1'b1};
    end
  end

  always_ff @(posedge clk_in) begin
    q <= d;
  end

  assign sync_out = q.s2;
endmodule : ifrw_sync2
